// *** svtd_pkg.sv ***
// What this block does
// - software picks trip level and crossing direction through the control register
// - supply crossing the level in the chosen direction sets the trip flag
// - an enabled trip flag raises the interrupt request to the processor
// - clearing the enable powers down detection; the mask register and the reference stable signal also gate the interrupt and arming
// - the unused control bit ignores writes and reads as zero
// - direction set: at or above level; cleared: at or below level
//
// constants and the trip evaluation stage of the supply trip detector.
// assumes one clock, asynchronous active-low reset, analog inputs already
// synchronous to the clock.
`timescale 1ns/1ns

// ==========================================================
// package
package svtd_pkg;
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;
    localparam int LEVEL_W = 4;
    localparam int EVT_W = 2;

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 2'h0;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 2'h1;
    localparam logic [ADDR_W-1:0] OFS_MASK = 2'h2;

    // control register fields
    localparam int BIT_DIR = 7;
    localparam int BIT_UNUSED = 6;
    localparam int BIT_STABLE = 5;
    localparam int BIT_EN = 4;
    localparam int LEVEL_LSB = 0;
    localparam logic [DATA_W-1:0] CONTROL_RESET = 8'h05;

    // status and mask fields
    localparam int EVT_TRIP = 0;
    localparam int EVT_STABLE = 1;
    localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;
    localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

    typedef enum logic [2:0] {
        ST_OFF = 3'h1,
        ST_SETTLE = 3'h2,
        ST_ARMED = 3'h4
    } svtd_state_e;
endpackage

// ==========================================================
// trip evaluation
module svtd_trip_eval (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic armed,
    input wire logic dir_rise,
    input wire logic at_or_above,
    input wire logic at_or_below,
    output logic trip_q
);
    // registered so the flag sees a clean one-cycle-old verdict
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            trip_q <= 1'b0;
        end else begin
            trip_q <= armed && (dir_rise ? at_or_above : at_or_below);
        end
    end
endmodule

// *** svtd_top.sv ***
// supply trip detector: control, status, mask registers and interrupt.
// assumes a simple register port with read data one cycle after the strobe
// and an analog front end giving comparator verdicts and a stable signal.
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module svtd_top (
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic [svtd_pkg::ADDR_W-1:0] ADDR,
    input wire logic [svtd_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [svtd_pkg::DATA_W-1:0] RDATA,
    input wire logic SUPPLY_AT_OR_ABOVE,
    input wire logic SUPPLY_AT_OR_BELOW,
    input wire logic REF_STABLE,
    output logic DETECTOR_POWER,
    output logic [svtd_pkg::LEVEL_W-1:0] TRIP_LEVEL,
    output logic IRQ
);
    // ======================================================
    // register decode
    function automatic logic hit(input logic [svtd_pkg::ADDR_W-1:0] a,
                                 input logic [svtd_pkg::ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    logic wr_control;
    logic wr_status;
    logic wr_mask;
    assign wr_control = WR && hit(ADDR, svtd_pkg::OFS_CONTROL);
    assign wr_status = WR && hit(ADDR, svtd_pkg::OFS_STATUS);
    assign wr_mask = WR && hit(ADDR, svtd_pkg::OFS_MASK);

    // ======================================================
    // control register
    logic dir_q;
    logic en_q;
    logic [svtd_pkg::LEVEL_W-1:0] level_q;
    localparam logic [svtd_pkg::DATA_W-1:0] RST = svtd_pkg::CONTROL_RESET;

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            dir_q <= RST[svtd_pkg::BIT_DIR];
            en_q <= RST[svtd_pkg::BIT_EN];
            level_q <= RST[svtd_pkg::LEVEL_LSB +: svtd_pkg::LEVEL_W];
        end else if (wr_control) begin
            // bits 6 and 5 are not stored: unused and read-only
            dir_q <= WDATA[svtd_pkg::BIT_DIR];
            en_q <= WDATA[svtd_pkg::BIT_EN];
            level_q <= WDATA[svtd_pkg::LEVEL_LSB +: svtd_pkg::LEVEL_W];
        end
    end

    assign DETECTOR_POWER = en_q;
    assign TRIP_LEVEL = level_q;

    // ======================================================
    // power and settle sequence
    svtd_pkg::svtd_state_e state_q;
    svtd_pkg::svtd_state_e state_d;
    logic stable_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            svtd_pkg::ST_OFF: begin
                if (en_q) begin
                    state_d = svtd_pkg::ST_SETTLE;
                end
            end
            svtd_pkg::ST_SETTLE: begin
                if (!en_q) begin
                    state_d = svtd_pkg::ST_OFF;
                end else if (REF_STABLE) begin
                    state_d = svtd_pkg::ST_ARMED;
                end
            end
            svtd_pkg::ST_ARMED: begin
                if (!en_q) begin
                    state_d = svtd_pkg::ST_OFF;
                end
            end
            default: begin
                state_d = svtd_pkg::ST_OFF;
            end
        endcase
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            state_q <= svtd_pkg::ST_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // a comparator on a settling reference gives noise, so only trust it
    // once the reference reports stable
    assign stable_q = (state_q == svtd_pkg::ST_ARMED);

    // ======================================================
    // trip evaluation
    logic trip;
    svtd_trip_eval u_eval (
        .clk(MCLK),
        .rst_b(RST_B),
        .armed(stable_q && en_q),
        .dir_rise(dir_q),
        .at_or_above(SUPPLY_AT_OR_ABOVE),
        .at_or_below(SUPPLY_AT_OR_BELOW),
        .trip_q(trip)
    );

    // ======================================================
    // status, mask, interrupt
    logic [svtd_pkg::EVT_W-1:0] evt;
    logic [svtd_pkg::EVT_W-1:0] status_q;
    logic [svtd_pkg::EVT_W-1:0] mask_q;
    logic stable_rise;

    assign stable_rise = (state_q == svtd_pkg::ST_SETTLE) &&
                         (state_d == svtd_pkg::ST_ARMED);
    assign evt[svtd_pkg::EVT_TRIP] = trip;
    assign evt[svtd_pkg::EVT_STABLE] = stable_rise;

    // flag stays set while the condition persists; set beats clear
    genvar gi;
    generate
        for (gi = 0; gi < svtd_pkg::EVT_W; gi++) begin : g_flag
            always_ff @(posedge MCLK or negedge RST_B) begin
                if (!RST_B) begin
                    status_q[gi] <= svtd_pkg::EVT_RESET[gi];
                end else if (evt[gi]) begin
                    status_q[gi] <= 1'b1;
                end else if (wr_status && WDATA[gi]) begin
                    status_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            mask_q <= svtd_pkg::EVT_RESET;
        end else if (wr_mask) begin
            mask_q <= WDATA[svtd_pkg::EVT_W-1:0];
        end
    end

    assign IRQ = |(status_q & mask_q);

    // ======================================================
    // read port
    logic [svtd_pkg::DATA_W-1:0] control_view;
    logic [svtd_pkg::DATA_W-1:0] rdata_d;

    always_comb begin
        control_view = svtd_pkg::READ_ZERO;
        control_view[svtd_pkg::BIT_DIR] = dir_q;
        control_view[svtd_pkg::BIT_UNUSED] = 1'b0;
        control_view[svtd_pkg::BIT_STABLE] = stable_q;
        control_view[svtd_pkg::BIT_EN] = en_q;
        control_view[svtd_pkg::LEVEL_LSB +: svtd_pkg::LEVEL_W] = level_q;
    end

    always_comb begin
        rdata_d = svtd_pkg::READ_ZERO;
        if (RD) begin
            case (ADDR)
                svtd_pkg::OFS_CONTROL: begin
                    rdata_d = control_view;
                end
                svtd_pkg::OFS_STATUS: begin
                    rdata_d[svtd_pkg::EVT_W-1:0] = status_q;
                end
                svtd_pkg::OFS_MASK: begin
                    rdata_d[svtd_pkg::EVT_W-1:0] = mask_q;
                end
                default: begin
                    rdata_d = svtd_pkg::READ_ZERO;
                end
            endcase
        end
    end

    // data stands for the single cycle after the strobe, zero otherwise
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            RDATA <= svtd_pkg::READ_ZERO;
        end else begin
            RDATA <= rdata_d;
        end
    end

    // ======================================================
    // checks
    sequence s_rise_cond;
        stable_q && en_q && dir_q && SUPPLY_AT_OR_ABOVE;
    endsequence

    sequence s_fall_cond;
        stable_q && en_q && !dir_q && SUPPLY_AT_OR_BELOW;
    endsequence

    sequence s_ctrl_read;
        RD && ADDR == svtd_pkg::OFS_CONTROL;
    endsequence

    a_level_follows: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        wr_control |=>
            TRIP_LEVEL ==
                $past(WDATA[svtd_pkg::LEVEL_LSB +: svtd_pkg::LEVEL_W]) &&
            dir_q == $past(WDATA[svtd_pkg::BIT_DIR]))
        else $error("trip level or direction not taken from write");

    a_rise_sets_flag: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        s_rise_cond ##1 1'b1 |=> status_q[svtd_pkg::EVT_TRIP])
        else $error("rising crossing did not set trip flag");

    a_fall_sets_flag: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        s_fall_cond ##1 1'b1 |=> status_q[svtd_pkg::EVT_TRIP])
        else $error("falling crossing did not set trip flag");

    a_no_wrong_dir: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        (dir_q && !SUPPLY_AT_OR_ABOVE) |=> !trip)
        else $error("trip raised for wrong direction");

    a_irq_enabled: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        (status_q[svtd_pkg::EVT_TRIP] && mask_q[svtd_pkg::EVT_TRIP])
        |-> IRQ)
        else $error("enabled trip flag without interrupt");

    a_irq_cause: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        IRQ |-> (status_q & mask_q) != '0)
        else $error("interrupt without unmasked flag");

    a_off_no_trip: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        !en_q |-> !DETECTOR_POWER ##1 (!trip && !stable_q))
        else $error("detector active while powered down");

    a_unused_zero: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        s_ctrl_read |=> !RDATA[svtd_pkg::BIT_UNUSED])
        else $error("unused control bit read as one");

    a_ctrl_layout: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        // the view is captured at the strobe; stable may move a cycle later
        s_ctrl_read |=> RDATA[svtd_pkg::BIT_DIR] == $past(dir_q) &&
            RDATA[svtd_pkg::BIT_EN] == $past(en_q) &&
            RDATA[svtd_pkg::BIT_STABLE] == $past(stable_q) &&
            RDATA[svtd_pkg::LEVEL_LSB +: svtd_pkg::LEVEL_W] ==
                $past(level_q))
        else $error("control register read layout wrong");

    a_reset_value: assert property (
        @(posedge MCLK)
        // two reset samples, so power-up unknowns are never judged
        !RST_B ##1 !RST_B |->
            dir_q == RST[svtd_pkg::BIT_DIR] &&
            en_q == RST[svtd_pkg::BIT_EN] &&
            level_q == RST[svtd_pkg::LEVEL_LSB +: svtd_pkg::LEVEL_W])
        else $error("control reset value wrong");
endmodule

// *** svtd_top_bench.sv ***
// self-checking bench for the supply trip detector top level.
// assumes the analog verdicts and reference stable flag are driven here
// as plain synchronous levels standing in for the front end.
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
        n_errors++; \
        $display("Error %s expected %h seen %h", nm, exp, got); \
    end \
end

module svtd_top_bench;
    logic MCLK;
    logic RST_B;
    logic [svtd_pkg::ADDR_W-1:0] ADDR;
    logic [svtd_pkg::DATA_W-1:0] WDATA;
    logic WR;
    logic RD;
    logic [svtd_pkg::DATA_W-1:0] RDATA;
    logic SUPPLY_AT_OR_ABOVE;
    logic SUPPLY_AT_OR_BELOW;
    logic REF_STABLE;
    logic DETECTOR_POWER;
    logic [svtd_pkg::LEVEL_W-1:0] TRIP_LEVEL;
    logic IRQ;
    int n_errors = 0;
    int num_checks = 0;

    svtd_top DUT (
        .MCLK(MCLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA),
        .SUPPLY_AT_OR_ABOVE(SUPPLY_AT_OR_ABOVE),
        .SUPPLY_AT_OR_BELOW(SUPPLY_AT_OR_BELOW),
        .REF_STABLE(REF_STABLE), .DETECTOR_POWER(DETECTOR_POWER),
        .TRIP_LEVEL(TRIP_LEVEL), .IRQ(IRQ)
    );

    // ==========================================================
    // clock and access tasks
    initial begin
        MCLK = 1'b0;
        forever #25 MCLK = ~MCLK;
    end

    task automatic close_out;
        if (n_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge MCLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge MCLK);
        WR <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe is taken
    task automatic rd_chk(input logic [1:0] a, input logic [7:0] e,
                          input string nm);
        @(posedge MCLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge MCLK);
        RD <= 1'b0;
        #1;
        `CHK(nm, e, RDATA)
    endtask

    task automatic set_cond(input logic ab, input logic be);
        @(posedge MCLK);
        SUPPLY_AT_OR_ABOVE <= ab;
        SUPPLY_AT_OR_BELOW <= be;
        repeat (4) @(posedge MCLK);
    endtask

    // flag is level-sensitive, so the verdict is dropped before clearing
    task automatic trip_case(input logic dir, input logic ab,
                             input logic be, input logic hit);
        wr(svtd_pkg::OFS_CONTROL, {dir, 3'h1, 4'ha});
        set_cond(ab, be);
        rd_chk(svtd_pkg::OFS_STATUS, {7'h00, hit}, "trip flag");
        set_cond(1'b0, 1'b0);
        wr(svtd_pkg::OFS_STATUS, 8'h03);
        rd_chk(svtd_pkg::OFS_STATUS, 8'h00, "trip clear");
    endtask

    // ==========================================================
    // watchdog
    initial begin
        #(50 * 4000);
        n_errors++;
        close_out;
    end

    // ==========================================================
    // tests
    initial begin
        RST_B = 1'b0;
        ADDR = 2'h0;
        WDATA = 8'h00;
        WR = 1'b0;
        RD = 1'b0;
        SUPPLY_AT_OR_ABOVE = 1'b0;
        SUPPLY_AT_OR_BELOW = 1'b0;
        REF_STABLE = 1'b0;
        repeat (2) @(posedge MCLK);
        RST_B <= 1'b1;
        #1;
        `CHK("level out", 4'h5, TRIP_LEVEL)
        `CHK("power out", 1'b0, DETECTOR_POWER)
        `CHK("irq", 1'b0, IRQ)
        rd_chk(svtd_pkg::OFS_CONTROL, 8'h05, "control reset");
        rd_chk(svtd_pkg::OFS_STATUS, 8'h00, "status reset");
        rd_chk(svtd_pkg::OFS_MASK, 8'h00, "mask reset");
        wr(svtd_pkg::OFS_CONTROL, 8'hfa);
        #1;
        `CHK("level out", 4'ha, TRIP_LEVEL)
        `CHK("power out", 1'b1, DETECTOR_POWER)
        rd_chk(svtd_pkg::OFS_CONTROL, 8'h9a, "control bits");
        // read data must drop back to zero after its single cycle
        @(posedge MCLK);
        #1;
        `CHK("rdata idle", 8'h00, RDATA)
        // no trip may be taken before the reference settles
        set_cond(1'b1, 1'b0);
        rd_chk(svtd_pkg::OFS_STATUS, 8'h00, "early trip");
        set_cond(1'b0, 1'b0);
        @(posedge MCLK);
        REF_STABLE <= 1'b1;
        repeat (4) @(posedge MCLK);
        rd_chk(svtd_pkg::OFS_CONTROL, 8'hba, "stable bit");
        rd_chk(svtd_pkg::OFS_STATUS, 8'h02, "stable event");
        wr(svtd_pkg::OFS_MASK, 8'h02);
        #1;
        `CHK("irq", 1'b1, IRQ)
        wr(svtd_pkg::OFS_MASK, 8'h00);
        wr(svtd_pkg::OFS_STATUS, 8'h02);
        rd_chk(svtd_pkg::OFS_STATUS, 8'h00, "stable clear");
        trip_case(1'b1, 1'b1, 1'b0, 1'b1);
        trip_case(1'b1, 1'b0, 1'b1, 1'b0);
        trip_case(1'b0, 1'b0, 1'b1, 1'b1);
        trip_case(1'b0, 1'b1, 1'b0, 1'b0);
        wr(svtd_pkg::OFS_MASK, 8'h01);
        set_cond(1'b0, 1'b1);
        #1;
        `CHK("irq", 1'b1, IRQ)
        set_cond(1'b0, 1'b0);
        wr(svtd_pkg::OFS_STATUS, 8'h01);
        #1;
        `CHK("irq", 1'b0, IRQ)
        wr(svtd_pkg::OFS_MASK, 8'h00);
        set_cond(1'b0, 1'b1);
        #1;
        `CHK("irq", 1'b0, IRQ)
        rd_chk(svtd_pkg::OFS_STATUS, 8'h01, "masked flag");
        // clear while the crossing still holds: the set must win
        wr(svtd_pkg::OFS_STATUS, 8'h01);
        rd_chk(svtd_pkg::OFS_STATUS, 8'h01, "set beats clear");
        set_cond(1'b0, 1'b0);
        wr(svtd_pkg::OFS_STATUS, 8'h01);
        // powered down: verdicts must be ignored
        wr(svtd_pkg::OFS_CONTROL, 8'h0a);
        #1;
        `CHK("power out", 1'b0, DETECTOR_POWER)
        set_cond(1'b0, 1'b1);
        rd_chk(svtd_pkg::OFS_STATUS, 8'h00, "off trip");
        rd_chk(svtd_pkg::OFS_CONTROL, 8'h0a, "off stable");
        wr(2'h3, 8'hff);
        rd_chk(2'h3, 8'h00, "unmapped");
        rd_chk(svtd_pkg::OFS_CONTROL, 8'h0a, "control kept");
        @(posedge MCLK);
        RST_B <= 1'b0;
        repeat (2) @(posedge MCLK);
        RST_B <= 1'b1;
        rd_chk(svtd_pkg::OFS_CONTROL, 8'h05, "control rerst");
        close_out;
    end
endmodule
